// ==== bench/core_model.sv ====
// Core model that issues flash writes, reads and lock reads.
`timescale 1ns/1ps
module core_model
	import flash_guard_pkg::*;
(
	// Clock and answers
	input  wire logic        clk_i,
	input  wire logic        spm_grant_i,
	input  wire logic        lpm_grant_i,
	// Requests
	output logic [PTR_W-1:0] ptr_o,
	output logic [PC_W-1:0]  pc_o,
	output logic             spm_req_o,
	output logic             lpm_req_o,
	output logic             lock_set_bit_o,
	output logic             self_program_enable_bit_o
);
	initial begin
		ptr_o = 16'h0000;
		pc_o = 13'h0000;
		{spm_req_o, lpm_req_o} = 2'h0;
		{lock_set_bit_o, self_program_enable_bit_o} = 2'h0;
	end

	// ==========================================================
	// Transfers
	// The pointer is inverted once released, so a stale value never
	// passes for a live request.
	task automatic access(input logic wr, input logic [PTR_W-1:0] p,
		input logic [PC_W-1:0] c, output logic g);
		@(negedge clk_i);
		ptr_o = wr ? {p[15:7], 7'h00} : p;
		pc_o = c;
		spm_req_o = wr;
		lpm_req_o = !wr;
		@(negedge clk_i);
		g = wr ? spm_grant_i : lpm_grant_i;
		ptr_o = ~p;
		spm_req_o = 1'b0;
		lpm_req_o = 1'b0;
	endtask

	task automatic lock_read(input int gap);
		@(negedge clk_i);
		ptr_o = LOCK_READ_PTR;
		lock_set_bit_o = 1'b1;
		self_program_enable_bit_o = 1'b1;
		@(negedge clk_i);
		lock_set_bit_o = 1'b0;
		self_program_enable_bit_o = 1'b0;
		repeat (gap) @(negedge clk_i);
		lpm_req_o = 1'b1;
		@(negedge clk_i);
		lpm_req_o = 1'b0;
		ptr_o = ~LOCK_READ_PTR;
	endtask
endmodule

// ==== bench/flash_section_lock_guard_tb.sv ====
// Self-checking bench for the flash section lock guard.
`timescale 1ns/1ps
module flash_section_lock_guard_tb;
	import flash_guard_pkg::*;
	localparam logic [12:0] boot_start [4] =
		'{13'h1C00, 13'h1E00, 13'h1F00, 13'h1F80};
	logic             ref_clk_i;
	logic             nrst_i;
	logic [7:0]       lock_nv_i;
	logic [1:0]       boot_size_nv_i;
	logic             lock_prog_i;
	logic [7:0]       lock_prog_data_i;
	logic             chip_erase_i;
	logic             vectors_in_boot_i;
	logic             ext_prog_req_i;
	logic             ext_verify_req_i;
	logic [PTR_W-1:0] ptr;
	logic [PC_W-1:0]  pc;
	logic [7:0]       mpb;
	logic [6:0]       page;
	logic [5:0]       word;
	logic             sr, lr, ls, se, sg, lg, lrd, clr, g;
	logic             irq, pok, vok, fuse, frz, stl, bsel;
	int               failures;
	int               total_checks;

	flash_section_lock_guard u_dut (
		.ref_clk_i, .nrst_i, .lock_nv_i, .boot_size_nv_i, .lock_prog_i,
		.lock_prog_data_i, .chip_erase_i, .vectors_in_boot_i,
		.ext_prog_req_i, .ext_verify_req_i,
		.ptr_i(ptr), .pc_i(pc), .spm_req_i(sr), .lpm_req_i(lr),
		.lock_set_bit_i(ls), .self_program_enable_bit_i(se),
		.spm_grant_o(sg), .lpm_grant_o(lg), .lock_read_o(lrd),
		.memory_protection_byte_o(mpb), .irq_enable_o(irq),
		.ext_prog_ok_o(pok), .ext_verify_ok_o(vok), .fuse_locked_o(fuse),
		.boot_lock_frozen_o(frz), .stall_region_o(stl),
		.page_index_o(page), .word_in_page_index_o(word),
		.byte_sel_o(bsel), .bits_cleared_o(clr));

	core_model core (.clk_i(ref_clk_i), .spm_grant_i(sg), .lpm_grant_i(lg),
		.ptr_o(ptr), .pc_o(pc), .spm_req_o(sr), .lpm_req_o(lr),
		.lock_set_bit_o(ls), .self_program_enable_bit_o(se));

	// ==========================================================
	// Shared tasks
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic test_done;
		if (failures == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic do_reset(input logic [1:0] sz);
		@(negedge ref_clk_i);
		nrst_i = 1'b0;
		boot_size_nv_i = sz;
		repeat (4) @(negedge ref_clk_i);
		nrst_i = 1'b1;
		repeat (6) @(negedge ref_clk_i);
	endtask

	// Erase first when asked, since an ordinary write only programs.
	task automatic set_lock(input logic [7:0] d, input logic e);
		chip_erase_i = e;
		@(negedge ref_clk_i);
		chip_erase_i = 1'b0;
		lock_prog_i = 1'b1;
		lock_prog_data_i = d;
		@(negedge ref_clk_i);
		lock_prog_i = 1'b0;
		@(negedge ref_clk_i);
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_lock_byte;
		chk(mpb, 8'hFF);
		set_lock(8'hC3, 1'b1);
		chk(mpb, 8'hC3);
		set_lock(8'hFF, 1'b0);
		chk(mpb, 8'hC3);
		set_lock(8'hFF, 1'b1);
		chk(mpb, 8'hFF);
	endtask

	task automatic t_fields;
		logic [PTR_W-1:0] p;
		for (int i = 0; i < 2; i++) begin
			p = i ? 16'hFFFF : 16'h4AAA;
			core.access(1'b0, p, 13'h0100, g);
			chk(page, p[13:7]);
			chk(word, p[6:1]);
			chk(bsel, p[0]);
			chk(stl, p[13:1] >= 13'h1C00);
		end
	endtask

	task automatic t_boot_size;
		logic [PC_W-1:0] s;
		for (int z = 0; z < 4; z++) begin
			do_reset(z[1:0]);
			set_lock(8'hEF, 1'b1);
			s = boot_start[z];
			core.access(1'b1, {2'h0, s - 13'h0040, 1'b0}, 13'h0100, g);
			chk(g, 1'b1);
			chk(stl, s - 13'h0040 >= 13'h1C00);
			core.access(1'b1, {2'h0, s, 1'b0}, 13'h0100, g);
			chk(g, 1'b0);
			chk(stl, 1'b1);
		end
	endtask

	task automatic t_modes;
		logic [1:0]       c;
		logic             a;
		logic [PTR_W-1:0] t;
		for (int m = 0; m < 8; m++) begin
			a = m[2];
			c = m[1:0];
			t = a ? 16'h0200 : 16'h3F00;
			vectors_in_boot_i = a;
			set_lock(a ? {4'hF, c, 2'h3} : {2'h3, c, 4'hF}, 1'b1);
			core.access(1'b1, t, a ? 13'h1F90 : 13'h0100, g);
			chk(g, c[0]);
			core.access(1'b0, t, a ? 13'h1F90 : 13'h0100, g);
			chk(g, c[1]);
			core.access(1'b0, t, a ? 13'h0100 : 13'h1F90, g);
			chk(g, 1'b1);
			chk(irq, c[1]);
		end
	endtask

	task automatic t_lock_read;
		set_lock(8'hE6, 1'b1);
		core.lock_read(2);
		chk(lrd, 1'b1);
		chk(clr, 1'b1);
		chk(mpb, 8'hE6);
		core.lock_read(3);
		chk(lrd, 1'b0);
	endtask

	task automatic t_mem_lock;
		for (int c = 0; c < 4; c++) begin
			set_lock({6'h3F, c[1:0]}, 1'b1);
			chk(pok, c == 3);
			chk(vok, c[1]);
			chk(fuse, c != 3);
			chk(frz, !c[1]);
			set_lock(8'hCF, 1'b0);
			chk(mpb, {2'h3, c[1] ? 2'h0 : 2'h3, 2'h3, c[1:0]});
		end
		ext_prog_req_i = 1'b0;
		ext_verify_req_i = 1'b0;
		@(negedge ref_clk_i);
		chk(pok, 1'b0);
		chk(vok, 1'b0);
	endtask

	// ==========================================================
	// Sequence
	initial begin
		ref_clk_i = 1'b0;
		forever #20 ref_clk_i = ~ref_clk_i;
	end

	initial begin
		#2ms;
		failures++;
		test_done();
	end

	initial begin
		failures = 0;
		total_checks = 0;
		nrst_i = 1'b0;
		lock_nv_i = 8'hFF;
		boot_size_nv_i = 2'h0;
		lock_prog_i = 1'b0;
		lock_prog_data_i = 8'hFF;
		chip_erase_i = 1'b0;
		vectors_in_boot_i = 1'b0;
		ext_prog_req_i = 1'b1;
		ext_verify_req_i = 1'b1;
		do_reset(2'h0);
		t_lock_byte();
		t_fields();
		t_boot_size();
		t_modes();
		t_lock_read();
		t_mem_lock();
		test_done();
	end
endmodule

// ==== hdl/flash_addr_decode.sv ====
// Pointer split and section membership decode.
`timescale 1ns/1ps
module flash_addr_decode
	import flash_guard_pkg::*;
(
	flash_req_if.dec r
);
	function automatic logic [PC_W-1:0] boot_start(input logic [1:0] c);
		unique case (c)
			2'h3: boot_start = BOOT_START_11;
			2'h2: boot_start = BOOT_START_10;
			2'h1: boot_start = BOOT_START_01;
			2'h0: boot_start = BOOT_START_00;
		endcase
	endfunction

	logic [PC_W-1:0] tgt_word;

	// Bits 15:14 never reach the decode.
	assign r.page     = r.ptr[PTR_PAGE_LSB +: PAGE_W];
	assign r.word     = r.ptr[PTR_WORD_LSB +: WORD_W];
	assign r.byte_sel = r.ptr[PTR_BYTE_BIT];
	assign tgt_word   = {r.page, r.word};
	assign r.tgt_boot = tgt_word >= boot_start(r.boot_size);
	assign r.exe_boot = r.pc >= boot_start(r.boot_size);
	assign r.tgt_stalling_read_region = tgt_word >= STALLING_READ_REGION_START;
endmodule

// ==== hdl/flash_guard_pkg.sv ====
// Constants shared by the flash section lock guard.
package flash_guard_pkg;

	// ==========================================================
	// Address layout
	localparam int PC_W          = 13;
	localparam int PTR_W         = 16;
	localparam int PAGE_W        = 7;
	localparam int WORD_W        = 6;
	localparam int PTR_PAGE_LSB  = 7;
	localparam int PTR_WORD_LSB  = 1;
	localparam int PTR_BYTE_BIT  = 0;
	localparam logic [PC_W-1:0] STALLING_READ_REGION_START = 13'h1C00;

	// ==========================================================
	// Boot section starts per size code
	localparam logic [PC_W-1:0] BOOT_START_11 = 13'h1F80;
	localparam logic [PC_W-1:0] BOOT_START_10 = 13'h1F00;
	localparam logic [PC_W-1:0] BOOT_START_01 = 13'h1E00;
	localparam logic [PC_W-1:0] BOOT_START_00 = 13'h1C00;
	localparam logic [1:0]      BOOT_SIZE_RST = 2'h0;

	// ==========================================================
	// Lock byte layout
	localparam int BOOT_LOCK_LSB = 4;
	localparam int APP_LOCK_LSB  = 2;
	localparam int MEM_LOCK_LSB  = 0;
	localparam logic [7:0] LOCK_RST = 8'hFF;
	localparam logic [PTR_W-1:0] LOCK_READ_PTR = 16'h0001;
	localparam logic [1:0] LOCK_WINDOW = 2'h3;

	// ==========================================================
	// Lock pair codes
	localparam logic [1:0] MODE_FREE  = 2'h3;
	localparam logic [1:0] MODE_WRITE = 2'h2;
	localparam logic [1:0] MODE_BOTH  = 2'h0;
	localparam logic [1:0] MODE_READ  = 2'h1;

	typedef enum logic [1:0] {
		LR_IDLE  = 2'b00,
		LR_ARMED = 2'b01
	} lock_read_e;

endpackage

// ==== hdl/flash_req_if.sv ====
// Decoded flash request carried between the guard's parts.
`timescale 1ns/1ps
interface flash_req_if;
	import flash_guard_pkg::*;
	logic [PTR_W-1:0] ptr;
	logic [PC_W-1:0]  pc;
	logic [1:0]       boot_size;
	logic [PAGE_W-1:0] page;
	logic [WORD_W-1:0] word;
	logic              byte_sel;
	logic              tgt_boot;
	logic              exe_boot;
	logic              tgt_stalling_read_region;
	modport src (output ptr, pc, boot_size,
		input page, word, byte_sel, tgt_boot, exe_boot, tgt_stalling_read_region);
	modport dec (input ptr, pc, boot_size,
		output page, word, byte_sel, tgt_boot, exe_boot, tgt_stalling_read_region);
endinterface

// ==== hdl/flash_section_lock_guard.sv ====
// Flash section lock guard: decides which flash accesses may proceed.
`timescale 1ns/1ps
module flash_section_lock_guard
	import flash_guard_pkg::*;
(
	// Clock and reset
	input  wire logic             ref_clk_i,
	input  wire logic             nrst_i,
	// Nonvolatile values presented at power-up
	input  wire logic [7:0]       lock_nv_i,
	input  wire logic [1:0]       boot_size_nv_i,
	// Lock programming and chip erase
	input  wire logic             lock_prog_i,
	input  wire logic [7:0]       lock_prog_data_i,
	input  wire logic             chip_erase_i,
	// Core requests
	input  wire logic [PTR_W-1:0] ptr_i,
	input  wire logic [PC_W-1:0]  pc_i,
	input  wire logic             spm_req_i,
	input  wire logic             lpm_req_i,
	input  wire logic             lock_set_bit_i,
	input  wire logic             self_program_enable_bit_i,
	input  wire logic             vectors_in_boot_i,
	// Programming port requests
	input  wire logic             ext_prog_req_i,
	input  wire logic             ext_verify_req_i,
	// Decisions
	output logic                  spm_grant_o,
	output logic                  lpm_grant_o,
	output logic                  lock_read_o,
	output logic [7:0]            memory_protection_byte_o,
	output logic                  irq_enable_o,
	output logic                  ext_prog_ok_o,
	output logic                  ext_verify_ok_o,
	output logic                  fuse_locked_o,
	output logic                  boot_lock_frozen_o,
	output logic                  stall_region_o,
	output logic [PAGE_W-1:0]     page_index_o,
	output logic [WORD_W-1:0]     word_in_page_index_o,
	output logic                  byte_sel_o,
	output logic                  bits_cleared_o
);
	// ==========================================================
	// Reset release
	logic [1:0] rst_sync;
	logic       rst_n;
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	// ==========================================================
	// Lock and fuse storage
	// Values are captured one cycle after reset release, since an async
	// reset may only load constants.
	logic [7:0] lock;
	logic [1:0] boot_size;
	logic       loaded;
	logic [1:0] mem_mode;
	logic [1:0] app_mode;
	logic [1:0] boot_mode;
	logic       mem_locked_full;

	assign mem_mode  = lock[MEM_LOCK_LSB +: 2];
	assign app_mode  = lock[APP_LOCK_LSB +: 2];
	assign boot_mode = lock[BOOT_LOCK_LSB +: 2];
	assign mem_locked_full = !mem_mode[1];

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			lock      <= LOCK_RST;
			boot_size <= BOOT_SIZE_RST;
			loaded    <= 1'b0;
		end else if (!loaded) begin
			lock      <= {LOCK_RST[7:6], lock_nv_i[5:0]};
			boot_size <= boot_size_nv_i;
			loaded    <= 1'b1;
		end else if (chip_erase_i) begin
			lock <= LOCK_RST;
		end else if (lock_prog_i) begin
			// Programming only clears bits; boot pair frozen when locked.
			lock[5:0] <= lock[5:0] & lock_prog_data_i[5:0];
			if (mem_locked_full) begin
				lock[5:4] <= lock[5:4];
			end
			// Bits 7:6 stay unprogrammed.
		end
	end

	// ==========================================================
	// Address decode
	flash_req_if req ();
	assign req.ptr       = ptr_i;
	assign req.pc        = pc_i;
	assign req.boot_size = boot_size;
	flash_addr_decode u_dec (
		.r (req.dec)
	);

	// ==========================================================
	// Access decisions
	logic wr_block;
	logic rd_block;
	logic irq_block;

	always_comb begin
		wr_block = 1'b0;
		rd_block = 1'b0;
		if (req.tgt_boot) begin
			wr_block = !boot_mode[0];
			rd_block = !req.exe_boot && !boot_mode[1];
		end else begin
			wr_block = !app_mode[0];
			rd_block = req.exe_boot && !app_mode[1];
		end
	end

	// Interrupts are only masked when vectors sit in the other section.
	assign irq_block = (vectors_in_boot_i && !req.exe_boot &&
		!app_mode[1]) ||
		(!vectors_in_boot_i && req.exe_boot && !boot_mode[1]);

	// ==========================================================
	// Lock byte read window
	lock_read_e lr_state;
	logic [1:0] lr_cnt;
	logic       lock_read_hit;
	logic       lr_expire;
	logic       next_cleared;

	assign lock_read_hit = (lr_state == LR_ARMED) && lpm_req_i &&
		(ptr_i == LOCK_READ_PTR);
	assign lr_expire = (lr_state == LR_ARMED) &&
		(lock_read_hit || lr_cnt == LOCK_WINDOW - 2'h1 || lpm_req_i);
	assign next_cleared = lr_expire;

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			lr_state <= LR_IDLE;
			lr_cnt   <= 2'h0;
		end else begin
			unique case (lr_state)
				LR_IDLE: begin
					lr_cnt <= 2'h0;
					if (lock_set_bit_i && self_program_enable_bit_i) begin
						lr_state <= LR_ARMED;
					end
				end
				LR_ARMED: begin
					lr_cnt <= lr_cnt + 2'h1;
					if (lr_expire) begin
						lr_state <= LR_IDLE;
					end
				end
			endcase
		end
	end

	// ==========================================================
	// Registered outputs
	// Blocked requests simply see no grant; a blocked read still closes an armed lock window.
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			spm_grant_o              <= 1'b0;
			lpm_grant_o              <= 1'b0;
			lock_read_o              <= 1'b0;
			memory_protection_byte_o <= LOCK_RST;
			irq_enable_o             <= 1'b0;
			bits_cleared_o           <= 1'b0;
		end else begin
			spm_grant_o <= spm_req_i && loaded && !wr_block &&
				(ptr_i[PTR_BYTE_BIT] == 1'b0);
			lpm_grant_o <= lpm_req_i && loaded && !rd_block &&
				!lock_read_hit;
			lock_read_o <= lock_read_hit;
			memory_protection_byte_o <= lock;
			irq_enable_o   <= loaded && !irq_block;
			bits_cleared_o <= next_cleared;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ext_prog_ok_o      <= 1'b0;
			ext_verify_ok_o    <= 1'b0;
			fuse_locked_o      <= 1'b1;
			boot_lock_frozen_o <= 1'b1;
		end else begin
			ext_prog_ok_o   <= ext_prog_req_i && loaded &&
				mem_mode == MODE_FREE;
			ext_verify_ok_o <= ext_verify_req_i && loaded &&
				!mem_locked_full;
			fuse_locked_o      <= !loaded || mem_mode != MODE_FREE;
			boot_lock_frozen_o <= !loaded || mem_locked_full;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			stall_region_o       <= 1'b0;
			page_index_o         <= '0;
			word_in_page_index_o <= '0;
			byte_sel_o           <= 1'b0;
		end else begin
			stall_region_o       <= req.tgt_stalling_read_region;
			page_index_o         <= req.page;
			word_in_page_index_o <= req.word;
			byte_sel_o           <= req.byte_sel;
		end
	end

	// ==========================================================
	// Checks on core requests
	// Grants are judged one edge after the request that they answer.
	app_write_blk_a: assert property (
		@(posedge ref_clk_i) disable iff (!rst_n)
		(loaded && spm_req_i && !req.tgt_boot && !app_mode[0])
		|=> !spm_grant_o) else $error("app write passed");
	boot_write_blk_a: assert property (
		@(posedge ref_clk_i) disable iff (!rst_n)
		(loaded && spm_req_i && req.tgt_boot && !boot_mode[0])
		|=> !spm_grant_o) else $error("boot write passed");
	app_read_blk_a: assert property (
		@(posedge ref_clk_i) disable iff (!rst_n)
		(lpm_req_i && req.exe_boot && !req.tgt_boot && !app_mode[1])
		|=> !lpm_grant_o) else $error("app read passed");
	boot_read_blk_a: assert property (
		@(posedge ref_clk_i) disable iff (!rst_n)
		(lpm_req_i && !req.exe_boot && req.tgt_boot && !boot_mode[1])
		|=> !lpm_grant_o) else $error("boot read passed");
	free_write_a: assert property (
		@(posedge ref_clk_i) disable iff (!rst_n)
		(loaded && spm_req_i && lock[5:2] == 4'hF && !ptr_i[0])
		|=> spm_grant_o) else $error("free write refused");
	app_irq_a: assert property (
		@(posedge ref_clk_i) disable iff (!rst_n)
		(loaded && vectors_in_boot_i && !req.exe_boot && !app_mode[1])
		|=> !irq_enable_o) else $error("app irq not masked");
	boot_irq_a: assert property (
		@(posedge ref_clk_i) disable iff (!rst_n)
		(loaded && !vectors_in_boot_i && req.exe_boot && !boot_mode[1])
		|=> !irq_enable_o) else $error("boot irq not masked");

	// ==========================================================
	// Checks on the programming port and lock storage
	ext_prog_a: assert property (
		@(posedge ref_clk_i) disable iff (!rst_n)
		(ext_prog_req_i && mem_mode != MODE_FREE)
		|=> !ext_prog_ok_o) else $error("locked prog passed");
	free_prog_a: assert property (
		@(posedge ref_clk_i) disable iff (!rst_n)
		(loaded && ext_prog_req_i && mem_mode == MODE_FREE)
		|=> ext_prog_ok_o) else $error("free prog refused");
	ext_verify_a: assert property (
		@(posedge ref_clk_i) disable iff (!rst_n)
		(ext_verify_req_i && !mem_mode[1])
		|=> !ext_verify_ok_o) else $error("locked verify");
	fuse_lock_a: assert property (
		@(posedge ref_clk_i) disable iff (!rst_n)
		(mem_mode != MODE_FREE)
		|=> fuse_locked_o) else $error("fuses left open");
	boot_freeze_a: assert property (
		@(posedge ref_clk_i) disable iff (!rst_n)
		(loaded && lock_prog_i && !chip_erase_i && mem_locked_full)
		|=> lock[BOOT_LOCK_LSB +: 2] == $past(lock[BOOT_LOCK_LSB +: 2]))
		else $error("boot pair changed");
	lock_clear_a: assert property (
		@(posedge ref_clk_i) disable iff (!rst_n)
		(loaded && !chip_erase_i)
		|=> (lock | $past(lock)) == $past(lock)) else $error("lock bit set");
	erase_restore_a: assert property (
		@(posedge ref_clk_i) disable iff (!rst_n)
		(loaded && chip_erase_i)
		|-> ##2 memory_protection_byte_o == LOCK_RST) else $error("erase failed");
	spare_bits_a: assert property (
		@(posedge ref_clk_i) disable iff (!rst_n)
		loaded
		|-> lock[7:6] == LOCK_RST[7:6]) else $error("spare bits programmed");
	size_held_a: assert property (
		@(posedge ref_clk_i) disable iff (!rst_n)
		loaded
		|=> $stable(boot_size)) else $error("boot size moved");

	// ==========================================================
	// Checks on the lock byte read window
	// A counter bounds the window, since a long repetition would be slow.
	logic [2:0] armed_len;
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			armed_len <= 3'h0;
		end else if (lr_state == LR_ARMED) begin
			armed_len <= armed_len + 3'h1;
		end else begin
			armed_len <= 3'h0;
		end
	end
	lock_window_a: assert property (
		@(posedge ref_clk_i) disable iff (!rst_n)
		(lr_state == LR_IDLE) ##1 (lr_state == LR_ARMED)
		|-> ##[1:3] (lr_state == LR_IDLE)) else $error("window");
	window_len_a: assert property (
		@(posedge ref_clk_i) disable iff (!rst_n)
		1'b1
		|-> armed_len <= {1'b0, LOCK_WINDOW}) else $error("window too long");
	lock_hit_a: assert property (
		@(posedge ref_clk_i) disable iff (!rst_n)
		lock_read_hit
		|=> lock_read_o && bits_cleared_o && !lpm_grant_o) else $error("hit");
	no_window_a: assert property (
		@(posedge ref_clk_i) disable iff (!rst_n)
		(lr_state == LR_IDLE)
		|=> !lock_read_o) else $error("lock read unarmed");

	// ==========================================================
	// Checks on the pointer fields
	page_map_a: assert property (
		@(posedge ref_clk_i) disable iff (!rst_n)
		1'b1 |=> page_index_o == $past(ptr_i[13:7]))
		else $error("page field");
	word_map_a: assert property (
		@(posedge ref_clk_i) disable iff (!rst_n)
		1'b1 |=> word_in_page_index_o == $past(ptr_i[6:1]))
		else $error("word field");
	byte_map_a: assert property (
		@(posedge ref_clk_i) disable iff (!rst_n)
		1'b1 |=> byte_sel_o == $past(ptr_i[0]))
		else $error("byte select");
	stall_map_a: assert property (
		@(posedge ref_clk_i) disable iff (!rst_n)
		1'b1 |=> stall_region_o == ($past(ptr_i[13:1]) >= STALLING_READ_REGION_START))
		else $error("stall region");
endmodule
